// *** src/ext_bus_pkg.sv ***
// Package for the external bus, reset stretcher and boot select block.
// Assumes one clock, the slow reference clock at 25 MHz, nothing else.
package ext_bus_pkg;

    // Bus widths
    localparam int ADDR_W         = 22;
    localparam int DATA_W         = 16;
    localparam int NUM_SEL        = 6;

    // Reset qualifier and stretcher counts, in reference clock cycles
    localparam int QUAL_CYCLES    = 3;
    localparam int STRETCH_CYCLES = 7;
    localparam int BOOT_LATCH_AHEAD = 3;
    localparam int CNT_W          = 4;

    // Chip select reset defaults
    localparam logic [3:0] BOOT_WAIT_RESET = 4'hF;
    localparam logic [7:0] BOOT_MATCH_RESET = 8'h00;
    localparam logic [5:0] SEL_ENABLE_RESET = 6'h01;
    localparam logic [5:0] GPO_LEVEL_RESET  = 6'h1E;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h000000;

    // Boot targets
    localparam logic [31:0] ROM_BOOT_ADDR   = 32'h00000000;
    localparam logic [31:0] FLASH_BOOT_ADDR = 32'h40000000;

    // One chip select's programming
    typedef struct packed {
        logic [7:0] match;
        logic [3:0] wait_states;
    } sel_cfg_t;

    // Internal bus request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [1:0]  byte_en;
        logic [15:0] wdata;
    } bus_req_t;

    // Bus sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_DONE   = 3'b100
    } bus_state_t;

    // Reset stretcher states
    typedef enum logic [2:0] {
        RS_RUN     = 3'b001,
        RS_HOLD    = 3'b010,
        RS_STRETCH = 3'b100
    } rst_state_t;

endpackage : ext_bus_pkg

// *** src/reset_qualifier.sv ***
// Qualifies one active-low reset request by a run-length count.
// Assumes request input already synchronous to the reference clock.
`timescale 1ns/1ps
module reset_qualifier
#(
    parameter int QUAL = 3
)
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic req_n,
    output logic      qualified
);
    logic [3:0] run_reg;

    // Count consecutive low cycles; saturate at the threshold
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || req_n)
            run_reg <= 4'h0;
        else if (run_reg < 4'(QUAL))
            run_reg <= run_reg + 4'h1;
    end

    assign qualified = (run_reg >= 4'(QUAL)) && !req_n;
endmodule : reset_qualifier

// *** src/chip_select_decode.sv ***
// Decodes one chip select from internal address bits 31 to 24.
// Assumes configuration is stable while a cycle is running.
`timescale 1ns/1ps
module chip_select_decode
(
    input  wire logic [7:0] addr_hi,
    input  wire logic [7:0] match,
    input  wire logic       active,
    output logic            hit
);
    // Hit only while a bus cycle uses the address
    assign hit = active && (addr_hi == match);
endmodule : chip_select_decode

// *** src/external_bus_reset_boot.sv ***
// External memory bus, reset request qualifier and stretcher, boot latch.
// Assumes one reference clock; pins are three signals, pads do the keeping.
// Chip select programming arrives on plain ports, not a register bus.
`timescale 1ns/1ps

// Function
// - address holds last value when idle
// - data lines undriven, pad keepers hold level
// - access type high read, low write
// - access type doubles as write strobe
// - upper lane enable low for upper byte
// - lower lane enable low for lower byte
// - option turns lane enables into write enables
// - output enable low only in reads
// - boot select on match, 15 waits reset
// - selects one-four low, reset GPO high
// - select five high, reset GPO low
// - reset request qualified after three cycles
// - reset output low at least seven cycles
// - assert on qualify, release seven after
// - latch boot mode three before release
// - low boot select fetches from flash
// - high boot select fetches from ROM
// - alternate pin resets when multiplexed
// - slow reference clock is default source
module external_bus_reset_boot
(
    input  wire logic                      ref_clk,
    input  wire logic                      nrst,
    // Internal request side
    input  wire ext_bus_pkg::bus_req_t     bus_req,
    output logic                           bus_ready,
    output logic [15:0]                    bus_rdata,
    output logic                           bus_done,
    // Programming
    input  wire ext_bus_pkg::sel_cfg_t [5:0] sel_cfg,
    input  wire logic [5:0]                sel_enable,
    input  wire logic                      sel_cfg_load,
    input  wire logic [5:0]                gpo_level,
    input  wire logic                      byte_write_mode,
    // External pins
    output logic [21:0]                    ext_address_out,
    input  wire logic [15:0]               ext_data_in,
    output logic [15:0]                    ext_data_out,
    output logic [15:0]                    ext_data_oe,
    output logic                           read_write,
    output logic                           output_enable_n,
    output logic                           upper_byte_lane_en_n,
    output logic                           lower_byte_lane_en_n,
    output logic                           boot_select_n,
    output logic [3:0]                     region_selects_n,
    output logic                           region_select_high,
    // Reset and boot
    input  wire logic                      reset_request_n,
    input  wire logic                      uart_rts_n,
    input  wire logic                      pin_alternate_select,
    input  wire logic                      watchdog_expired,
    input  wire logic                      boot_source_select,
    output logic                           reset_out_n,
    output logic                           boot_from_rom,
    output logic [31:0]                    boot_fetch_addr,
    output logic                           clock_source_fast
);
    ext_bus_pkg::bus_state_t state_reg;
    ext_bus_pkg::rst_state_t rst_state_reg;
    ext_bus_pkg::sel_cfg_t [5:0] cfg_reg;
    logic [5:0]  sel_en_reg;
    logic [5:0]  gpo_reg;
    logic [5:0]  hit;
    logic [3:0]  wait_reg;
    logic [3:0]  wait_target;
    logic        write_reg;
    logic [1:0]  lanes_reg;
    logic [31:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [ext_bus_pkg::ADDR_W-1:0] ext_addr_reg;
    logic [ext_bus_pkg::CNT_W-1:0]  stretch_reg;
    logic        qual_main;
    logic        qual_alt;
    logic        reset_req;
    logic        boot_reg;
    logic        active;
    // Cycle qualifiers for the strobes, the read capture, the sequencer and the boot latch
    logic        rd_cycle;
    logic        wr_cycle;
    logic        lane_gate;
    logic        last_wait;
    logic        boot_window;

    // slow clock default, nothing here switches it
    // Moving to the fast clock belongs to the clock block
    assign clock_source_fast = 1'b0;

    // Primary request pin qualifier
    // A pulse shorter than the run length never reaches the stretcher
    reset_qualifier #(.QUAL(ext_bus_pkg::QUAL_CYCLES)) u_qual_main
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .req_n     (reset_request_n),
        .qualified (qual_main)
    );

    // alternate pin only when multiplexed in
    reset_qualifier #(.QUAL(ext_bus_pkg::QUAL_CYCLES)) u_qual_alt
    (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .req_n     (uart_rts_n | !pin_alternate_select),
        .qualified (qual_alt)
    );

    // any qualified source or watchdog
    // Watchdog is internal and trusted, so it skips the qualifier
    assign reset_req = qual_main || qual_alt || watchdog_expired;

    // Stretcher: hold while requested, then count down
    // A request inside the stretch restarts the full count
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            rst_state_reg <= ext_bus_pkg::RS_RUN;
            stretch_reg   <= '0;
        end
        else
        begin
            unique case (rst_state_reg)
                ext_bus_pkg::RS_RUN:
                begin
                    if (reset_req)
                        rst_state_reg <= ext_bus_pkg::RS_HOLD;
                end
                ext_bus_pkg::RS_HOLD:
                begin
                    // Loaded one short: the zero count is the last low cycle
                    if (!reset_req)
                    begin
                        rst_state_reg <= ext_bus_pkg::RS_STRETCH;
                        stretch_reg   <= 4'(ext_bus_pkg::STRETCH_CYCLES - 1);
                    end
                end
                ext_bus_pkg::RS_STRETCH:
                begin
                    // seven more cycles, restart on new request
                    if (reset_req)
                        rst_state_reg <= ext_bus_pkg::RS_HOLD;
                    else if (stretch_reg == 4'h0)
                        rst_state_reg <= ext_bus_pkg::RS_RUN;
                    else
                        stretch_reg <= stretch_reg - 4'h1;
                end
                default:
                    rst_state_reg <= ext_bus_pkg::RS_RUN;
            endcase
        end
    end

    // output low in hold and stretch
    // Decoded from state only, so it cannot glitch between edges
    assign reset_out_n = (rst_state_reg == ext_bus_pkg::RS_RUN);

    // Latch point: the count equals the cycles left before release
    assign boot_window = (rst_state_reg == ext_bus_pkg::RS_STRETCH) && !reset_req
                         && (stretch_reg == 4'(ext_bus_pkg::BOOT_LATCH_AHEAD));

    // sample boot select three cycles before release
    // Later changes of the strap pin are ignored until the next reset
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            boot_reg <= 1'b1;
        else if (boot_window)
            boot_reg <= boot_source_select;
    end

    assign boot_from_rom   = boot_reg;
    assign boot_fetch_addr = boot_reg ? ext_bus_pkg::ROM_BOOT_ADDR
                                      : ext_bus_pkg::FLASH_BOOT_ADDR;

    // programmable decode, waits and select choice
    // Held at defaults under reset_out_n too, so a watchdog reset
    // brings back the boot select and the general output levels
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !reset_out_n)
        begin
            for (int i = 0; i < 6; i++)
            begin
                cfg_reg[i].match       <= ext_bus_pkg::BOOT_MATCH_RESET;
                cfg_reg[i].wait_states <= ext_bus_pkg::BOOT_WAIT_RESET;
            end
            sel_en_reg <= ext_bus_pkg::SEL_ENABLE_RESET;
            gpo_reg    <= ext_bus_pkg::GPO_LEVEL_RESET;
        end
        else if (sel_cfg_load)
        begin
            cfg_reg    <= sel_cfg;
            sel_en_reg <= sel_enable;
            gpo_reg    <= gpo_level;
        end
    end

    // One decoder per select
    // Selects assert only in access cycles, never on an idle bus
    assign active = (state_reg == ext_bus_pkg::ST_ACCESS);
    for (genvar g = 0; g < 6; g++)
    begin : g_dec
        chip_select_decode u_dec
        (
            .addr_hi (addr_reg[31:24]),
            .match   (cfg_reg[g].match),
            .active  (active && sel_en_reg[g]),
            .hit     (hit[g])
        );
    end

    // boot select low on match
    // Enabled from reset so the first fetch can reach external flash
    assign boot_select_n = !hit[0];
    // selects one-four low, else GPO level
    // General outputs take their level straight from the loaded word
    for (genvar k = 1; k < 5; k++)
    begin : g_mid
        assign region_selects_n[k-1] = sel_en_reg[k] ? !hit[k] : gpo_reg[k];
    end
    // select five active high, else GPO level
    assign region_select_high = sel_en_reg[5] ? hit[5] : gpo_reg[5];

    // Wait count of the first matching select
    // Lowest index wins when two selects share a match value
    always_comb
    begin
        wait_target = '0;
        for (int i = 5; i >= 0; i--)
            if (sel_en_reg[i] && addr_reg[31:24] == cfg_reg[i].match)
                wait_target = cfg_reg[i].wait_states;
    end

    // Last cycle of the access, shared by sequencer and read capture
    assign last_wait = (wait_reg == wait_target);

    // Bus sequencer: one access of wait_target+1 cycles
    // One request at a time; valid is ignored until idle again
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !reset_out_n)
        begin
            state_reg <= ext_bus_pkg::ST_IDLE;
            wait_reg  <= '0;
            write_reg <= 1'b0;
            lanes_reg <= 2'h0;
            addr_reg  <= 32'h00000000;
            wdata_reg <= 16'h0000;
        end
        else
        begin
            unique case (state_reg)
                ext_bus_pkg::ST_IDLE:
                begin
                    if (bus_req.valid)
                    begin
                        state_reg <= ext_bus_pkg::ST_ACCESS;
                        write_reg <= bus_req.write;
                        lanes_reg <= bus_req.byte_en;
                        addr_reg  <= bus_req.addr;
                        wdata_reg <= bus_req.wdata;
                        wait_reg  <= '0;
                    end
                end
                ext_bus_pkg::ST_ACCESS:
                begin
                    if (last_wait)
                        state_reg <= ext_bus_pkg::ST_DONE;
                    else
                        wait_reg <= wait_reg + 4'h1;
                end
                ext_bus_pkg::ST_DONE:
                    state_reg <= ext_bus_pkg::ST_IDLE;
                default:
                    state_reg <= ext_bus_pkg::ST_IDLE;
            endcase
        end
    end

    // Handshake to the internal side
    // Ready drops under reset output, so no access starts in reset
    assign bus_ready = (state_reg == ext_bus_pkg::ST_IDLE) && reset_out_n;
    assign bus_done  = (state_reg == ext_bus_pkg::ST_DONE);

    // address only moves when a cycle starts
    // Holding the pins saves needless toggling on an idle bus
    always_ff @(posedge ref_clk)
    begin
        if (!nrst || !reset_out_n)
            ext_addr_reg <= ext_bus_pkg::ADDR_RESET;
        else if (state_reg == ext_bus_pkg::ST_IDLE && bus_req.valid)
            ext_addr_reg <= bus_req.addr[21:0];
    end
    assign ext_address_out = ext_addr_reg;

    // Read data captured on the last wait cycle
    // Output enable is still low here, so the slave is driving
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            bus_rdata <= 16'h0000;
        else if (rd_cycle && last_wait)
            bus_rdata <= ext_data_in;
    end

    // Qualified cycle kinds; reset_out_n also guards a sequencer mid-reset
    assign rd_cycle = active && !write_reg && reset_out_n;
    assign wr_cycle = active && write_reg && reset_out_n;

    // release data pins when idle or in reset
    // Pad keepers hold the level, so nothing here drives an idle bus
    assign ext_data_out = wdata_reg;
    assign ext_data_oe  = {16{wr_cycle}};

    // high for read and idle, low during write
    // same pin serves as memory write strobe
    assign read_write = !wr_cycle;

    // output enable low only in a read
    // The slave may drive the data lines only while this is low
    assign output_enable_n = !rd_cycle;

    // byte write mode gates lanes to writes only
    // Reads then leave both lanes high, as byte-write static memories expect
    assign lane_gate = !byte_write_mode || write_reg;

    assign upper_byte_lane_en_n = !(active && reset_out_n && lanes_reg[1] && lane_gate);
    assign lower_byte_lane_en_n = !(active && reset_out_n && lanes_reg[0] && lane_gate);

endmodule : external_bus_reset_boot

// *** dv/external_bus_reset_boot_properties.sv ***
// Checker for the external bus, reset stretcher and boot latch block.
// Sees only top-level ports; attached by the bind after the module.
`timescale 1ns/1ps
module external_bus_reset_boot_properties
(
    input wire logic                  ref_clk,
    input wire logic                  nrst,
    input wire ext_bus_pkg::bus_req_t bus_req,
    input wire logic                  bus_ready,
    input wire logic                  byte_write_mode,
    input wire logic [21:0]           ext_address_out,
    input wire logic [15:0]           ext_data_oe,
    input wire logic                  read_write,
    input wire logic                  output_enable_n,
    input wire logic                  upper_byte_lane_en_n,
    input wire logic                  lower_byte_lane_en_n,
    input wire logic [3:0]            region_selects_n,
    input wire logic                  region_select_high,
    input wire logic                  reset_request_n,
    input wire logic                  reset_out_n
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // Request taken on this edge
    logic take;
    assign take = bus_ready && bus_req.valid;

    property p_reset_levels;
        $past(!nrst) |-> read_write && upper_byte_lane_en_n && lower_byte_lane_en_n
            && output_enable_n && region_selects_n == 4'hF && !region_select_high;
    endproperty
    a_reset_levels: assert property (p_reset_levels) else $error("reset levels");
    // Previous cycle idle too, so a fresh take is not mistaken
    property p_idle_address;
        bus_ready && $past(bus_ready) |-> $stable(ext_address_out);
    endproperty
    a_idle_address: assert property (p_idle_address) else $error("address moved");
    property p_lanes;
        take && !byte_write_mode |=> {upper_byte_lane_en_n, lower_byte_lane_en_n}
            == ~$past(bus_req.byte_en);
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane enables");
    property p_read_strobes;
        take && !bus_req.write |=> !output_enable_n && read_write && ext_data_oe == 16'h0000;
    endproperty
    a_read_strobes: assert property (p_read_strobes) else $error("read strobes");
    property p_write_strobes;
        take && bus_req.write |=> !read_write && output_enable_n && ext_data_oe == 16'hFFFF;
    endproperty
    a_write_strobes: assert property (p_write_strobes) else $error("write strobes");
    property p_idle_quiet;
        bus_ready |-> output_enable_n && read_write && ext_data_oe == 16'h0000;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle bus driven");
    property p_qualify;
        (!reset_request_n) [*4] |=> !reset_out_n;
    endproperty
    a_qualify: assert property (p_qualify) else $error("request not taken");
    property p_stretch;
        !reset_out_n && $rose(reset_request_n) ##0 reset_request_n [*7]
            |=> !reset_out_n ##1 reset_out_n;
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch length");
endmodule : external_bus_reset_boot_properties

bind external_bus_reset_boot external_bus_reset_boot_properties chk (.*);

// *** dv/ext_memory_model.sv ***
// Behavioural sixteen-word memory standing on the external bus pins.
// Assumes writes while access type is low, reads while enable is low.
`timescale 1ns/1ps
module ext_memory_model
(
    input  wire logic        ref_clk,
    input  wire logic [21:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        ub_n,
    input  wire logic        lb_n,
    output logic      [15:0] rdata
);
    logic [15:0] mem_reg [16];
    logic [15:0] last_reg = 16'h0000;

    // write strobe
    // Each byte lane written only under its own enable
    always @(posedge ref_clk)
    begin
        if (!we_n && !ub_n)
            mem_reg[addr[3:0]][15:8] <= wdata[15:8];
        if (!we_n && !lb_n)
            mem_reg[addr[3:0]][7:0] <= wdata[7:0];
        last_reg <= rdata;
    end

    // drive on read
    // Released bus toggles every cycle, so a stale value never passes
    assign rdata = oe_n ? ~last_reg : mem_reg[addr[3:0]];
endmodule : ext_memory_model

// *** dv/external_bus_reset_boot_bench.sv ***
// Self-checking bench for the external bus, reset stretcher and boot latch.
// Inputs change 1 ns after the rising edge; memory model sits on the pins.
`timescale 1ns/1ps
module external_bus_reset_boot_bench;
    typedef struct packed {
        logic        wr;
        logic        bwm;
        logic [31:0] addr;
        logic [1:0]  be;
        logic [15:0] wd;
        logic [4:0]  waits;
        logic [5:0]  sel;
        logic [15:0] rd;
    } row_t;

    logic                        ref_clk = 1'h0;
    logic                        nrst = 1'h0;
    logic                        sel_cfg_load = 1'h0;
    logic                        byte_write_mode = 1'h0;
    logic                        reset_request_n = 1'h1;
    logic                        uart_rts_n = 1'h1;
    logic                        pin_alternate_select = 1'h0;
    logic                        watchdog_expired = 1'h0;
    logic                        boot_source_select = 1'h1;
    logic [5:0]                  sel_enable = 6'h23;
    logic [5:0]                  gpo_level = 6'h14;
    ext_bus_pkg::bus_req_t       bus_req = '0;
    ext_bus_pkg::sel_cfg_t [5:0] sel_cfg = {12'h051, 12'h00F, 12'h00F, 12'h00F, 12'h022, 12'h00F};
    logic                        bus_ready, bus_done, read_write, output_enable_n;
    logic                        upper_byte_lane_en_n, lower_byte_lane_en_n, boot_select_n;
    logic                        region_select_high, reset_out_n, boot_from_rom, clock_source_fast;
    logic [3:0]                  region_selects_n;
    logic [15:0]                 bus_rdata, ext_data_in, ext_data_out, ext_data_oe;
    logic [21:0]                 ext_address_out;
    logic [31:0]                 boot_fetch_addr;
    int                          fails = 0;
    int                          tests_run = 0;
    int                          n;
    // Write, mode, address, lanes, data, waits, selects seen, read data
    row_t rows [10] = '{
        '{1'h1, 1'h0, 32'h013FFFF3, 2'h3, 16'h1234, 5'h00, 6'h36, 16'h0000},
        '{1'h1, 1'h0, 32'h013FFFF3, 2'h2, 16'hAAFF, 5'h00, 6'h36, 16'h0000},
        '{1'h1, 1'h0, 32'h013FFFF3, 2'h1, 16'h00CC, 5'h00, 6'h36, 16'h0000},
        '{1'h0, 1'h0, 32'h013FFFF3, 2'h3, 16'h0000, 5'h00, 6'h36, 16'hAACC},
        '{1'h1, 1'h0, 32'h00000000, 2'h3, 16'h5A5A, 5'h0F, 6'h16, 16'h0000},
        '{1'h0, 1'h0, 32'h02000000, 2'h3, 16'h0000, 5'h02, 6'h34, 16'h5A5A},
        '{1'h0, 1'h0, 32'h05000003, 2'h3, 16'h0000, 5'h01, 6'h37, 16'hAACC},
        '{1'h0, 1'h1, 32'h013FFFF3, 2'h3, 16'h0000, 5'h00, 6'h36, 16'hAACC},
        '{1'h1, 1'h1, 32'h013FFFF3, 2'h1, 16'h0011, 5'h00, 6'h36, 16'h0000},
        '{1'h0, 1'h0, 32'h013FFFF3, 2'h3, 16'h0000, 5'h00, 6'h36, 16'hAA11}};
    // Pins grouped for short compares
    wire [3:0] strobes = {read_write, output_enable_n, upper_byte_lane_en_n, lower_byte_lane_en_n};
    wire [5:0] sel_pins = {boot_select_n, region_selects_n, region_select_high};

    external_bus_reset_boot dut (.*);

    ext_memory_model mem (.ref_clk(ref_clk), .addr(ext_address_out), .wdata(ext_data_out),
        .we_n(read_write), .oe_n(output_enable_n), .ub_n(upper_byte_lane_en_n),
        .lb_n(lower_byte_lane_en_n), .rdata(ext_data_in));

    always #20 ref_clk = ~ref_clk;

    task complete_run;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    // Bounded wait on ready (0), done (1) or reset release (2); boot flips late in a release
    task wait_for(input int which, input int lim);
        n = 0;
        while (n < lim && (which == 0 ? bus_ready : which == 1 ? bus_done : reset_out_n) !== 1'h1)
        begin
            tick;
            n++;
            if (which == 2 && n == 5)
                boot_source_select = ~boot_source_select;
        end
        if (n == lim)
        begin
            fails++;
            $display("wrong value wait bound: expected below %0d, seen %0d", lim, n);
            complete_run;
        end
    endtask : wait_for

    // One access, checked in its first cycle, at completion and when idle again
    task access(input row_t w);
        logic [3:0] exp_s;
        byte_write_mode = w.bwm;
        wait_for(0, 40);
        bus_req = '{1'h1, w.wr, w.addr, w.be, w.wd};
        tick;
        bus_req.valid = 1'h0;
        exp_s = {~w.wr, w.wr, (w.bwm & ~w.wr) ? 2'h3 : ~w.be};
        check(ext_address_out, w.addr[21:0], "address");
        check(strobes, exp_s, "strobes");
        check(ext_data_oe, w.wr ? 16'hFFFF : 16'h0000, "data enable");
        check(sel_pins, w.sel, "selects");
        wait_for(1, 40);
        check(n, w.waits + 5'h01, "wait count");
        if (!w.wr)
            check(bus_rdata, w.rd, "read data");
        tick;
        tick;
        check(ext_address_out, w.addr[21:0], "idle address");
    endtask : access

    // Qualified request on either pin, stretched release, boot latch
    task stretch(input logic alt, input logic boot);
        logic [32:0] exp_b;
        pin_alternate_select = alt;
        boot_source_select = boot;
        reset_request_n = alt;
        uart_rts_n = ~alt;
        repeat (4) tick;
        check(reset_out_n, 1'h0, "reset asserted");
        repeat (6) tick;
        reset_request_n = 1'h1;
        uart_rts_n = 1'h1;
        wait_for(2, 20);
        check(n, 8, "stretch length");
        exp_b = {boot, boot ? ext_bus_pkg::ROM_BOOT_ADDR : ext_bus_pkg::FLASH_BOOT_ADDR};
        check({boot_from_rom, boot_fetch_addr}, exp_b, "boot");
        pin_alternate_select = 1'h0;
    endtask : stretch

    initial
    begin
        repeat (16) @(posedge ref_clk);
        #1;
        nrst = 1'h1;
        check(strobes, 4'hF, "reset strobes");
        check(sel_pins, 6'h3E, "reset selects");
        check({reset_out_n, boot_from_rom, clock_source_fast}, 3'h6, "reset outs");
        check({ext_address_out, ext_data_oe}, 38'h0, "reset bus");
        sel_cfg_load = 1'h1;
        tick;
        sel_cfg_load = 1'h0;
        tick;
        check(sel_pins, 6'h36, "general outputs");
        $display("test reset and load done");
        foreach (rows[r])
        begin
            access(rows[r]);
            $display("test row %0d done", r);
        end
        // Short request and unselected alternate pin are both ignored
        reset_request_n = 1'h0;
        tick;
        tick;
        reset_request_n = 1'h1;
        uart_rts_n = 1'h0;
        repeat (5) tick;
        uart_rts_n = 1'h1;
        check(reset_out_n, 1'h1, "ignored requests");
        stretch(1'h0, 1'h0);
        stretch(1'h1, 1'h1);
        $display("test reset requests done");
        // Watchdog needs no qualification but still gets the full stretch
        watchdog_expired = 1'h1;
        tick;
        watchdog_expired = 1'h0;
        wait_for(2, 30);
        check(n, 8, "watchdog stretch");
        check(boot_from_rom, 1'h0, "watchdog boot");
        $display("test watchdog done");
        complete_run;
    end
endmodule : external_bus_reset_boot_bench
